// file: atm_tx_pkg.sv
// constants and types for the atm cell transmit framer
package atm_tx_pkg;
   // register offsets (word index on the plain register port)
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_POLL_RANGE = 5'h01;
   localparam logic [4:0] REG_MAP_IDX = 5'h02;
   localparam logic [4:0] REG_MAP_DATA = 5'h03;
   localparam logic [4:0] REG_POLL_RESULT = 5'h04;
   localparam logic [4:0] REG_CELL_CNT = 5'h05;
   localparam logic [4:0] REG_IDLE_CNT = 5'h06;
   localparam logic [4:0] REG_STAT_STATUS = 5'h07;
   localparam logic [4:0] REG_STAT_MASK = 5'h08;
   localparam logic [4:0] REG_STAT_PORT = 5'h09;
   localparam logic [4:0] REG_STAT_VPVC = 5'h0A;
   localparam logic [4:0] REG_IDLE_VPVC = 5'h0B;
   // control register fields
   localparam int CTRL_MPHY_BIT = 0;
   localparam int CTRL_OCTET_BIT = 1;
   localparam int CTRL_HEC_BIT = 2;
   localparam int CTRL_COSET_BIT = 3;
   localparam int CTRL_EN_BIT = 4;
   localparam logic [4:0] CTRL_RESET = 5'h14;
   localparam logic [4:0] POLL_RANGE_RESET = 5'h00;
   localparam logic [4:0] POLL_RANGE_MAX = 5'h19;
   localparam logic [4:0] ADDR_ALL_ONES = 5'h1F;
   localparam logic [7:0] HEC_COSET = 8'h55;
   localparam logic [5:0] BYTES_FROM_FIFO = 6'h34;
   localparam logic [5:0] BYTES_NO_HEC = 6'h35;
   localparam logic [2:0] OCTET_SLACK = 3'h4;
   localparam logic [27:0] IDLE_VPVC_RESET = 28'h0000000;
   localparam int NUM_PORTS = 32;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_WAIT = 3'b001,
      TX_HDR = 3'b010,
      TX_HEC = 3'b011,
      TX_BODY = 3'b100
   } tx_state_t;

   // one crc-8 step (x^8+x^2+x+1) over a whole byte
   function automatic logic [7:0] hec_step(input logic [7:0] crc, input logic [7:0] d);
      logic [7:0] c;
      c = crc ^ d;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
      end
      return c;
   endfunction
endpackage

// file: atm_tx_sync.sv
// two flop synchroniser for pin inputs
`timescale 1ns/1ps
module atm_tx_sync (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic d,
   output logic q
);
   logic meta_r;
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         meta_r <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // atm_tx_sync

// file: atm_tx_stat_counter.sv
// 32-bit statistics counter with sticky rollover flag
`timescale 1ns/1ps
module atm_tx_stat_counter (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic inc,
   input wire logic clr,
   output logic [31:0] count_r,
   output logic ovf_r
);
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         count_r <= 32'h00000000;
      end else if (clr) begin
         count_r <= inc ? 32'h00000001 : 32'h00000000;
      end else if (inc) begin
         count_r <= count_r + 32'h00000001;
      end
   end
   // set beats clear so a rollover in the clearing cycle survives
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ovf_r <= 1'b0;
      end else if (inc && count_r == 32'hFFFFFFFF) begin
         ovf_r <= 1'b1;
      end else if (clr) begin
         ovf_r <= 1'b0;
      end
   end
endmodule // atm_tx_stat_counter

// file: atm_cell_phy_transmit.sv
// atm cell transmit framer: phy polling, cell send, hec insert, statistics
`timescale 1ns/1ps
module atm_cell_phy_transmit (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic tx_link_clk,
   input wire logic [4:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic stat_irq,
   input wire logic fifo_cell_ready,
   input wire logic [4:0] fifo_port,
   input wire logic [7:0] fifo_data,
   output logic fifo_pop,
   output logic [7:0] tx_data,
   output logic tx_soc,
   output logic tx_transfer_enable_out_n,
   output logic [4:0] tx_phy_select_lines,
   output logic [4:0] rx_phy_select_lines,
   input wire logic tx_cell_space_indication
);
   logic clk_s, clk_d_r, link_rise;
   logic space_s;
   logic [4:0] ctrl_r;
   logic [4:0] poll_range_r;
   logic [4:0] map_idx_r;
   logic [4:0] map_r [0:atm_tx_pkg::NUM_PORTS-1];
   logic [31:0] poll_result_r;
   logic [4:0] poll_log_r;
   logic poll_phase_r;
   logic [4:0] poll_pending_r;
   logic poll_pending_vld_r;
   atm_tx_pkg::tx_state_t state_r;
   logic [4:0] cur_port_r;
   logic [5:0] byte_cnt_r;
   logic [7:0] hec_r;
   logic [2:0] slack_r;
   logic [31:0] hdr_r;
   logic cell_match_r;
   logic [4:0] stat_port_r;
   logic [27:0] stat_vpvc_r;
   logic [27:0] idle_vpvc_r;
   logic [1:0] stat_mask_r;
   logic [31:0] cell_cnt, idle_cnt;
   logic cell_ovf, idle_ovf;
   logic cell_inc, idle_inc;
   logic cell_clr, idle_clr;
   logic mphy, octet, hec_on, coset, enable;
   logic can_send, sending;
   logic [5:0] body_len;
   logic in_cell;
   logic last_byte;

   assign mphy = ctrl_r[atm_tx_pkg::CTRL_MPHY_BIT];
   // multi-phy forces cell level handshake
   assign octet = ctrl_r[atm_tx_pkg::CTRL_OCTET_BIT] && !mphy;
   assign hec_on = ctrl_r[atm_tx_pkg::CTRL_HEC_BIT];
   assign coset = ctrl_r[atm_tx_pkg::CTRL_COSET_BIT];
   assign enable = ctrl_r[atm_tx_pkg::CTRL_EN_BIT];
   assign body_len = hec_on ? atm_tx_pkg::BYTES_FROM_FIFO : atm_tx_pkg::BYTES_NO_HEC;

   atm_tx_sync u_clk_sync (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .d(tx_link_clk),
      .q(clk_s)
   );
   atm_tx_sync u_space_sync (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .d(tx_cell_space_indication),
      .q(space_s)
   );

   // link work advances on each sampled rising edge of the link clock
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         clk_d_r <= 1'b0;
      end else begin
         clk_d_r <= clk_s;
      end
   end
   // both flops clear in reset, so a low link clock gives no false first edge
   assign link_rise = clk_s && !clk_d_r;

   // register writes
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl_r <= atm_tx_pkg::CTRL_RESET;
         poll_range_r <= atm_tx_pkg::POLL_RANGE_RESET;
         map_idx_r <= 5'h00;
         stat_port_r <= 5'h00;
         stat_vpvc_r <= 28'h0000000;
         idle_vpvc_r <= atm_tx_pkg::IDLE_VPVC_RESET;
         stat_mask_r <= 2'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            atm_tx_pkg::REG_CTRL: ctrl_r <= reg_wdata[4:0];
            atm_tx_pkg::REG_POLL_RANGE: begin
               // sweep longer than 26 ports cannot fit the two clock poll
               poll_range_r <= (reg_wdata[4:0] > atm_tx_pkg::POLL_RANGE_MAX) ?
                  atm_tx_pkg::POLL_RANGE_MAX : reg_wdata[4:0];
            end
            atm_tx_pkg::REG_MAP_IDX: map_idx_r <= reg_wdata[4:0];
            atm_tx_pkg::REG_STAT_MASK: stat_mask_r <= reg_wdata[1:0];
            atm_tx_pkg::REG_STAT_PORT: stat_port_r <= reg_wdata[4:0];
            atm_tx_pkg::REG_STAT_VPVC: stat_vpvc_r <= reg_wdata[27:0];
            atm_tx_pkg::REG_IDLE_VPVC: idle_vpvc_r <= reg_wdata[27:0];
            default: ;
         endcase
      end
   end

   // logical to physical table, identity after reset
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         for (int i = 0; i < atm_tx_pkg::NUM_PORTS; i++) begin
            map_r[i] <= 5'(i);
         end
      end else if (reg_wr && reg_addr == atm_tx_pkg::REG_MAP_DATA) begin
         map_r[map_idx_r] <= reg_wdata[4:0];
      end
   end

   // only a write to a counter clears it; reads have no side effect
   assign cell_clr = reg_wr && reg_addr == atm_tx_pkg::REG_CELL_CNT;
   assign idle_clr = reg_wr && reg_addr == atm_tx_pkg::REG_IDLE_CNT;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            atm_tx_pkg::REG_CTRL: reg_rdata <= {27'h0000000, ctrl_r};
            atm_tx_pkg::REG_POLL_RANGE: reg_rdata <= {27'h0000000, poll_range_r};
            atm_tx_pkg::REG_MAP_IDX: reg_rdata <= {27'h0000000, map_idx_r};
            atm_tx_pkg::REG_MAP_DATA: reg_rdata <= {27'h0000000, map_r[map_idx_r]};
            atm_tx_pkg::REG_POLL_RESULT: reg_rdata <= poll_result_r;
            atm_tx_pkg::REG_CELL_CNT: reg_rdata <= cell_cnt;
            atm_tx_pkg::REG_IDLE_CNT: reg_rdata <= idle_cnt;
            atm_tx_pkg::REG_STAT_STATUS: reg_rdata <= {30'h00000000, idle_ovf, cell_ovf};
            atm_tx_pkg::REG_STAT_MASK: reg_rdata <= {30'h00000000, stat_mask_r};
            atm_tx_pkg::REG_STAT_PORT: reg_rdata <= {27'h0000000, stat_port_r};
            atm_tx_pkg::REG_STAT_VPVC: reg_rdata <= {4'h0, stat_vpvc_r};
            atm_tx_pkg::REG_IDLE_VPVC: reg_rdata <= {4'h0, idle_vpvc_r};
            default: reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // poller: address out on one link edge, answer sampled on the next
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         poll_log_r <= 5'h00;
         poll_phase_r <= 1'b0;
         poll_pending_r <= 5'h00;
         poll_pending_vld_r <= 1'b0;
      end else if (!mphy || !enable) begin
         poll_log_r <= 5'h00;
         poll_phase_r <= 1'b0;
         poll_pending_vld_r <= 1'b0;
      end else if (link_rise) begin
         poll_phase_r <= !poll_phase_r;
         if (!poll_phase_r) begin
            poll_pending_r <= poll_log_r;
            poll_pending_vld_r <= 1'b1;
         end else begin
            poll_pending_vld_r <= 1'b0;
            // wrap back to logical zero after the range value
            poll_log_r <= (poll_log_r >= poll_range_r) ? 5'h00 : poll_log_r + 5'h01;
         end
      end
   end

   // response arrives one link clock after the poll address
   // a stale answer is overwritten on the next sweep, never cleared
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         poll_result_r <= 32'h00000000;
      end else if (mphy && link_rise && poll_phase_r && poll_pending_vld_r) begin
         poll_result_r[poll_pending_r] <= space_s;
      end
   end

   // chosen port on a phase-b edge in TX_WAIT, poll address on every phase-a edge
   // polling keeps its phase-a edges; the chosen port goes out on phase b
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         tx_phy_select_lines <= atm_tx_pkg::ADDR_ALL_ONES;
      end else if (!mphy) begin
         tx_phy_select_lines <= atm_tx_pkg::ADDR_ALL_ONES;
      end else if (link_rise && !poll_phase_r) begin
         tx_phy_select_lines <= map_r[poll_log_r];
      end else if (link_rise && state_r == atm_tx_pkg::TX_WAIT) begin
         tx_phy_select_lines <= map_r[cur_port_r];
      end
   end
   assign rx_phy_select_lines = atm_tx_pkg::ADDR_ALL_ONES;

   // octet mode slack: four bytes may follow a withdrawn space indication
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         slack_r <= atm_tx_pkg::OCTET_SLACK;
      end else if (space_s) begin
         slack_r <= atm_tx_pkg::OCTET_SLACK;
      end else if (link_rise && sending && slack_r != 3'h0) begin
         slack_r <= slack_r - 3'h1;
      end
   end
   assign can_send = octet ? (space_s || slack_r != 3'h0) : 1'b1;

   // cell-level: in multi-phy the chosen port's poll result grants the cell
   assign in_cell = state_r == atm_tx_pkg::TX_HDR || state_r == atm_tx_pkg::TX_HEC ||
      state_r == atm_tx_pkg::TX_BODY;
   assign sending = in_cell && can_send;
   // the check byte is made here, so its edge takes nothing from the fifo
   assign fifo_pop = link_rise && sending && state_r != atm_tx_pkg::TX_HEC;
   // last body byte of the cell, shared by the sequencer and the statistics
   assign last_byte = state_r == atm_tx_pkg::TX_BODY && byte_cnt_r == body_len - 6'h01;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_r <= atm_tx_pkg::TX_IDLE;
         cur_port_r <= 5'h00;
         byte_cnt_r <= 6'h00;
         hec_r <= 8'h00;
         hdr_r <= 32'h00000000;
         tx_data <= 8'h00;
         tx_soc <= 1'b0;
         tx_transfer_enable_out_n <= 1'b1;
      end else if (link_rise) begin
         tx_soc <= 1'b0;
         tx_transfer_enable_out_n <= 1'b1;
         case (state_r)
            atm_tx_pkg::TX_IDLE: begin
               if (enable && fifo_cell_ready) begin
                  cur_port_r <= mphy ? fifo_port : 5'h00;
                  state_r <= atm_tx_pkg::TX_WAIT;
               end
            end
            atm_tx_pkg::TX_WAIT: begin
               // cell level waits for space; octet level starts at once
               // multi-phy leaves on a phase-b edge, where the select lines take
               // the chosen port, so that phy sees its address before enable drops
               if (octet || (mphy ? (poll_result_r[cur_port_r] && poll_phase_r) :
                  space_s)) begin
                  state_r <= atm_tx_pkg::TX_HDR;
                  byte_cnt_r <= 6'h00;
                  hec_r <= 8'h00;
               end
            end
            atm_tx_pkg::TX_HDR: begin
               if (can_send) begin
                  tx_data <= fifo_data;
                  tx_soc <= byte_cnt_r == 6'h00;
                  tx_transfer_enable_out_n <= 1'b0;
                  hec_r <= atm_tx_pkg::hec_step(hec_r, fifo_data);
                  hdr_r <= {hdr_r[23:0], fifo_data};
                  byte_cnt_r <= byte_cnt_r + 6'h01;
                  if (byte_cnt_r == 6'h03) begin
                     state_r <= hec_on ? atm_tx_pkg::TX_HEC : atm_tx_pkg::TX_BODY;
                  end
               end
            end
            atm_tx_pkg::TX_HEC: begin
               if (can_send) begin
                  tx_data <= coset ? (hec_r ^ atm_tx_pkg::HEC_COSET) : hec_r;
                  tx_transfer_enable_out_n <= 1'b0;
                  state_r <= atm_tx_pkg::TX_BODY;
               end
            end
            atm_tx_pkg::TX_BODY: begin
               if (can_send) begin
                  tx_data <= fifo_data;
                  tx_transfer_enable_out_n <= 1'b0;
                  byte_cnt_r <= byte_cnt_r + 6'h01;
                  if (last_byte) begin
                     state_r <= atm_tx_pkg::TX_IDLE;
                  end
               end
            end
            default: state_r <= atm_tx_pkg::TX_IDLE;
         endcase
      end
   end

   // a cell matches at its last body byte on stat_port_r; idle cells share the same match, only the vpvc differs
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cell_match_r <= 1'b0;
      end else begin
         cell_match_r <= link_rise && can_send && last_byte && cur_port_r == stat_port_r;
      end
   end
   // header stays in hdr_r until the next cell starts, so the match is stable
   assign cell_inc = cell_match_r && hdr_r[31:4] == stat_vpvc_r;
   assign idle_inc = cell_match_r && hdr_r[31:4] == idle_vpvc_r;

   atm_tx_stat_counter u_cell_cnt (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .inc(cell_inc),
      .clr(cell_clr),
      .count_r(cell_cnt),
      .ovf_r(cell_ovf)
   );
   atm_tx_stat_counter u_idle_cnt (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .inc(idle_inc),
      .clr(idle_clr),
      .count_r(idle_cnt),
      .ovf_r(idle_ovf)
   );

   assign stat_irq = |({idle_ovf, cell_ovf} & stat_mask_r);
endmodule // atm_cell_phy_transmit

// file: atm_cell_phy_transmit_asserts.sv
// port checker for the atm cell transmit framer
`timescale 1ns/1ps
module atm_cell_phy_transmit_asserts (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic fifo_pop,
   input wire logic [7:0] tx_data,
   input wire logic tx_soc,
   input wire logic tx_transfer_enable_out_n,
   input wire logic [4:0] rx_phy_select_lines
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   logic [6:0] pop_cnt_r;
   logic [6:0] pop_cnt_nxt;
   logic soc_d_r;
   // pops since the last start of cell, the new cell's first pop included
   always_comb pop_cnt_nxt = (tx_soc && !soc_d_r) ? 7'h01 : pop_cnt_r + {6'h00, fifo_pop};
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         pop_cnt_r <= 7'h00;
         soc_d_r <= 1'b0;
      end else begin
         pop_cnt_r <= pop_cnt_nxt;
         soc_d_r <= tx_soc;
      end
   end
   sequence soc_hold_s;
      tx_soc [*4];
   endsequence
   sequence soc_end_s;
      ##[1:8] !tx_soc;
   endsequence
   rx_lines_a: assert property (rx_phy_select_lines == atm_tx_pkg::ADDR_ALL_ONES)
      else $error("rx select lines not all ones");
   read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
      else $error("read data outside its cycle");
   soc_enable_a: assert property (tx_soc |-> !tx_transfer_enable_out_n)
      else $error("start of cell without enable");
   soc_pop_a: assert property ($rose(tx_soc) |-> $past(fifo_pop))
      else $error("first header byte not taken from fifo");
   pop_pulse_a: assert property (fifo_pop |=> !fifo_pop)
      else $error("fifo pop longer than one cycle");
   data_hold_a: assert property ($changed(tx_data) |=> $stable(tx_data) [*6])
      else $error("byte not held a link period");
   soc_len_a: assert property ($rose(tx_soc) |=> soc_hold_s ##0 soc_end_s)
      else $error("start of cell flag wrong length");
   pop_count_a: assert property ($rose(tx_soc) && pop_cnt_r != 7'h01 |->
      pop_cnt_r == 7'h35 || pop_cnt_r == 7'h36)
      else $error("wrong number of bytes popped per cell");
endmodule // atm_cell_phy_transmit_asserts

bind atm_cell_phy_transmit atm_cell_phy_transmit_asserts chk (.sys_clk, .nrst, .reg_rd,
   .reg_rdata, .fifo_pop, .tx_data, .tx_soc, .tx_transfer_enable_out_n, .rx_phy_select_lines);

// file: atm_phy_model.sv
// behavioural phy set answering polls and collecting sent bytes
`timescale 1ns/1ps
module atm_phy_model (
   input wire logic tx_link_clk,
   input wire logic [7:0] tx_data,
   input wire logic tx_soc,
   input wire logic tx_transfer_enable_out_n,
   input wire logic [4:0] tx_phy_select_lines,
   input wire logic [31:0] ready_mask,
   output logic tx_cell_space_indication,
   output logic [15:0] tot_r,
   output logic [7:0] late_r,
   output logic [7:0] hec_r,
   output logic [7:0] pay_r,
   output logic [4:0] cell_sel_r
);
   logic [5:0] idx_r;
   logic [4:0] last_sel_r;
   initial begin
      tx_cell_space_indication = 1'b0;
      {tot_r, late_r, hec_r, pay_r, idx_r} = '0;
      {cell_sel_r, last_sel_r} = '0;
   end
   always @(posedge tx_link_clk) begin
      // addressed phy answers one link clock after its address appears
      tx_cell_space_indication <= ready_mask[tx_phy_select_lines];
      // a phy is chosen by the address it saw one edge before its first byte
      last_sel_r <= tx_phy_select_lines;
      if (!tx_transfer_enable_out_n) begin
         tot_r <= tot_r + 16'h0001;
         // bytes taken after space was withdrawn
         if (!tx_cell_space_indication) late_r <= late_r + 8'h01;
         idx_r <= tx_soc ? 6'h01 : idx_r + 6'h01;
         if (tx_soc) cell_sel_r <= last_sel_r;
         if (idx_r == 6'h04 && !tx_soc) hec_r <= tx_data;
         if (idx_r == 6'h05 && !tx_soc) pay_r <= tx_data;
      end
   end
endmodule // atm_phy_model

// file: atm_cell_phy_transmit_bench.sv
// self-checking bench for the atm cell transmit framer
`timescale 1ns/1ps
module atm_cell_phy_transmit_bench;
   logic sys_clk = 0, nrst = 0, tx_link_clk = 0, reg_wr = 0, reg_rd = 0, fcr = 0;
   logic stat_irq, fifo_pop, soc, en_n, space;
   logic [4:0] reg_addr = 0, fport = 0, tsel, rsel, csel;
   logic [31:0] reg_wdata = 0, reg_rdata, ready = 0;
   logic [7:0] fifo_data = 0, tx_data, hec, pay, late, late0;
   logic [15:0] tot, t0, t1;
   logic [7:0] cb [0:63];
   int pidx = 0, need = 0, errors = 0, samples_checked = 0;
   logic [31:0] hdr [0:2] = '{32'h0A1B2C30, 32'h00000001, 32'h0A1B2C30};
   logic [31:0] ctl [0:2] = '{32'h14, 32'h1C, 32'h14};
   logic [4:0] phys [0:4] = '{5'h03, 5'h05, 5'h07, 5'h09, 5'h16};
   always #25 sys_clk = ~sys_clk;
   initial begin
      #13;
      forever #200 tx_link_clk = ~tx_link_clk;
   end
   atm_cell_phy_transmit dut (.sys_clk(sys_clk), .nrst(nrst), .tx_link_clk(tx_link_clk),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .stat_irq(stat_irq), .fifo_cell_ready(fcr), .fifo_port(fport),
      .fifo_data(fifo_data), .fifo_pop(fifo_pop), .tx_data(tx_data), .tx_soc(soc),
      .tx_transfer_enable_out_n(en_n), .tx_phy_select_lines(tsel), .rx_phy_select_lines(rsel),
      .tx_cell_space_indication(space));
   atm_phy_model phy (.tx_link_clk(tx_link_clk), .tx_data(tx_data), .tx_soc(soc),
      .tx_transfer_enable_out_n(en_n), .tx_phy_select_lines(tsel), .ready_mask(ready),
      .tx_cell_space_indication(space), .tot_r(tot), .late_r(late), .hec_r(hec), .pay_r(pay),
      .cell_sel_r(csel));
   // fifo stand-in: next byte is presented after each pop
   always @(posedge sys_clk) begin
      if (fifo_pop) begin
         pidx <= pidx + 1;
         fifo_data <= cb[pidx+1];
         if (pidx + 1 == need) fcr <= 1'b0;
      end
   end
   function automatic logic [7:0] crc8(input logic [31:0] h);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction
   task stop_test;
      if (errors == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task rdc(input logic [4:0] a, input logic [31:0] e, input string n);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(n, e, reg_rdata);
   endtask
   task wait_tot(input logic [15:0] t);
      for (int n = 0; n < 4000 && tot < t; n++) @(posedge sys_clk);
      if (tot < t) begin
         chk("sent bytes", {16'h0, t}, {16'h0, tot});
         stop_test;
      end
   endtask
   task start(input logic [31:0] h, input logic [4:0] p, input int n);
      for (int i = 0; i < 64; i++) cb[i] = (i < 4) ? h[31-8*i -: 8] : 8'(i * 7 + 3);
      t0 = tot;
      @(posedge sys_clk);
      pidx <= 0;
      need <= n;
      fifo_data <= cb[0];
      fport <= p;
      fcr <= 1'b1;
   endtask
   task send(input logic [31:0] h, input logic [4:0] p, input int n);
      start(h, p, n);
      wait_tot(t0 + 16'd53);
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      rdc(atm_tx_pkg::REG_CTRL, {27'h0, atm_tx_pkg::CTRL_RESET}, "ctrl reset");
      wr(5'h1F, 32'hFFFFFFFF);
      rdc(5'h1F, 32'h0, "unmapped");
      chk("tx select", 32'h1F, {27'h0, tsel});
      chk("rx select", 32'h1F, {27'h0, rsel});
      wr(atm_tx_pkg::REG_STAT_PORT, 32'h0);
      wr(atm_tx_pkg::REG_STAT_VPVC, {4'h0, hdr[0][31:4]});
      ready <= 32'h80000000;
      for (int k = 0; k < 3; k++) begin
         wr(atm_tx_pkg::REG_CTRL, ctl[k]);
         send(hdr[k], 5'h00, 52);
         chk("hec", {24'h0, crc8(hdr[k]) ^ (ctl[k][3] ? 8'h55 : 8'h00)}, {24'h0, hec});
         chk("payload", {24'h0, cb[4]}, {24'h0, pay});
      end
      wr(atm_tx_pkg::REG_CTRL, 32'h10);
      send(32'h55667780, 5'h00, 53);
      chk("raw byte 4", {24'h0, cb[4]}, {24'h0, hec});
      chk("raw byte 5", {24'h0, cb[5]}, {24'h0, pay});
      chk("cell select", 32'h1F, {27'h0, csel});
      rdc(atm_tx_pkg::REG_CELL_CNT, 32'h2, "cell count");
      rdc(atm_tx_pkg::REG_CELL_CNT, 32'h2, "cell count reread");
      rdc(atm_tx_pkg::REG_IDLE_CNT, 32'h1, "idle count");
      wr(atm_tx_pkg::REG_CELL_CNT, 32'h0);
      rdc(atm_tx_pkg::REG_CELL_CNT, 32'h0, "cell count cleared");
      rdc(atm_tx_pkg::REG_STAT_STATUS, 32'h0, "overflow flags");
      wr(atm_tx_pkg::REG_STAT_MASK, 32'h3);
      rdc(atm_tx_pkg::REG_STAT_MASK, 32'h3, "irq mask");
      chk("irq", 32'h0, {31'h0, stat_irq});
      // octet handshake: space withdrawn mid-cell
      wr(atm_tx_pkg::REG_CTRL, 32'h16);
      late0 = late;
      start(hdr[0], 5'h00, 52);
      wait_tot(t0 + 16'd10);
      ready <= 32'h0;
      repeat (80) @(posedge sys_clk);
      t1 = tot;
      chk("late bytes", 32'h1, {31'h0, (late - late0) <= 8'h04});
      repeat (80) @(posedge sys_clk);
      chk("paused", {16'h0, t1}, {16'h0, tot});
      ready <= 32'h80000000;
      wait_tot(t0 + 16'd53);
      chk("octet hec", {24'h0, crc8(hdr[0])}, {24'h0, hec});
      // multi-phy polling through a scattered map
      for (int i = 0; i < 5; i++) begin
         wr(atm_tx_pkg::REG_MAP_IDX, i);
         wr(atm_tx_pkg::REG_MAP_DATA, {27'h0, phys[i]});
      end
      wr(atm_tx_pkg::REG_POLL_RANGE, 32'h4);
      ready <= 32'h00400020;
      wr(atm_tx_pkg::REG_CTRL, 32'h15);
      repeat (400) @(posedge sys_clk);
      rdc(atm_tx_pkg::REG_POLL_RESULT, 32'h12, "poll result");
      send(hdr[2], 5'h04, 52);
      chk("selected phy", 32'h16, {27'h0, csel});
      chk("multi hec", {24'h0, crc8(hdr[2])}, {24'h0, hec});
      ready <= 32'h00400000;
      repeat (400) @(posedge sys_clk);
      rdc(atm_tx_pkg::REG_POLL_RESULT, 32'h10, "poll update");
      wr(atm_tx_pkg::REG_POLL_RANGE, 32'h1F);
      rdc(atm_tx_pkg::REG_POLL_RANGE, 32'h19, "range clamp");
      wr(atm_tx_pkg::REG_CTRL, 32'h14);
      repeat (40) @(posedge sys_clk);
      chk("single select", 32'h1F, {27'h0, tsel});
      stop_test;
   end
endmodule // atm_cell_phy_transmit_bench
